/* File: bench/nbsp_node.sv */
// Remote serial node: sends frames on the port's input, captures its output.
// Assumes the caller enters its tasks just after a rising clock edge.
`timescale 1ns/100ps

module nbsp_node (
    input wire logic clk_i,
    input wire logic txd_i,
    input wire logic [7:0] bit_clks_i,
    input wire logic [3:0] frame_bits_i,
    output logic rxd_o,
    output logic [10:0] cap_o,
    output logic [15:0] cap_cnt_o
);
    initial begin
        rxd_o = 1'b1;
        cap_o = '0;
        cap_cnt_o = '0;
    end

    task automatic put(input logic b, input int n);
        rxd_o <= b;
        repeat (n) @(posedge clk_i);
    endtask : put

    task automatic send(input logic [7:0] d, input logic b9,
                        input logic nine, input logic stop, input int n);
        put(1'b0, n);
        for (int i = 0; i < 8; i++) put(d[i], n);
        if (nine) put(b9, n);
        put(stop, n);
        // Line has a pull-up, so released means high
        put(1'b1, 2);
    endtask : send

    // Short low pulse that looks like a start edge but votes high
    task automatic glitch(input int n);
        put(1'b0, n);
        put(1'b1, 1);
    endtask : glitch

    // *****
    // Capture of frames sent by the port, sampled mid-bit
    // *****
    always begin : grab
        @(negedge txd_i);
        repeat (bit_clks_i / 2) @(posedge clk_i);
        for (int i = 0; i < int'(frame_bits_i); i++) begin
            cap_o[i] = txd_i;
            if (i < frame_bits_i - 1) repeat (bit_clks_i) @(posedge clk_i);
        end
        cap_cnt_o = cap_cnt_o + 16'h0001;
    end
endmodule : nbsp_node

/* File: bench/nbsp_port_monitor.sv */
// Checker for the serial port: bus handshakes and serial bit timing.
// Assumes it is bound into nbsp_port and sees only that module's ports.
`timescale 1ns/100ps

module nbsp_port_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic txd_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [4:0] gap_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // *****
    // Cycles since the serial output last moved
    // *****
    // Saturates so the first edge after reset never looks short
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gap_ff <= 5'h1f;
        end else if ($changed(txd_o)) begin
            gap_ff <= 5'h00;
        end else if (gap_ff != 5'h1f) begin
            gap_ff <= gap_ff + 5'h01;
        end
    end

    // *****
    // Assertions
    // *****
    // A bit lasts 16 ticks and ticks come at most once per clock
    a_tx_bit_len: assert property (
        $changed(txd_o) |-> gap_ff >= 5'h0f)
        else $error("serial bit shorter than sixteen clocks");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer withdrawn early");
    a_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer withdrawn early");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_cause: assert property (
        $rose(s_axi_rvalid) |->
        $past(s_axi_arvalid) && $past(s_axi_arready))
        else $error("read answer without request");
    a_rdata_upper: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_aw_ready_drop: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("address ready stays high");
    a_w_ready_drop: assert property (
        s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("data ready stays high");
endmodule : nbsp_port_monitor

bind nbsp_port nbsp_port_monitor u_mon (.clk_i, .rst_n_i, .txd_o,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

/* File: bench/nbsp_port_test.sv */
// Self-checking bench for the serial port, registers over AXI4-Lite.
// Assumes the remote node model and the bound checker are compiled with it.
`timescale 1ns/100ps
`include "nbsp_consts.svh"

`define NBSP_CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
    end \
end

module nbsp_port_test;
    import nbsp_pkg::*;
    localparam logic [7:0] I_PWR = `NBSP_IDX_PWR;
    localparam logic [7:0] I_CTL = `NBSP_IDX_CTRL;
    localparam logic [7:0] I_BUF = `NBSP_IDX_BUF;
    localparam logic [7:0] I_ADR = `NBSP_IDX_SLAVE_MATCH_ADDRESS;
    localparam logic [7:0] I_MSK = `NBSP_IDX_SLAVE_MATCH_MASK;
    logic clk_i;
    logic rst_n_i = 1'b0;
    logic baud_ovf_i = 1'b0;
    logic rxd_i, txd_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
    logic [31:0] s_axi_rdata;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] node_blen = 8'h10;
    logic [3:0] node_bits = 4'hb;
    logic [10:0] cap;
    logic [15:0] cap_cnt;
    int error_cnt = 0, check_count = 0;

    nbsp_port #(.ADDR_W(12)) u_dut (.clk_i, .rst_n_i, .baud_ovf_i, .rxd_i,
        .txd_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    nbsp_node u_node (.clk_i, .txd_i(txd_o), .bit_clks_i(node_blen),
        .frame_bits_i(node_bits), .rxd_o(rxd_i), .cap_o(cap),
        .cap_cnt_o(cap_cnt));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Timer overflow pulse every second clock
    always @(posedge clk_i) baud_ovf_i <= ~baud_ovf_i;

    // *****
    // Bus and helper tasks
    // *****
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic hang;
        `NBSP_CHK(1'b0, 1'b1)
        final_report();
    endtask : hang

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        n = 0;
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        s_axi_bready <= 1'b0;
        last_resp = s_axi_bresp;
        if (n >= 100) hang();
    endtask : wr

    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        int n;
        @(posedge clk_i);
        n = 0;
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        last_resp = s_axi_rresp;
        if (n >= 100) hang();
    endtask : rd

    task automatic wait_cap(input int target);
        int n;
        n = 0;
        while (cap_cnt < target && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 3000) hang();
    endtask : wait_cap

    // *****
    // Scenarios
    // *****
    task automatic t_regs;
        logic [31:0] v;
        rd(I_ADR, v); `NBSP_CHK(v, 32'h0)
        rd(I_MSK, v); `NBSP_CHK(v, 32'h0)
        rd(8'h00, v); `NBSP_CHK({last_resp, v}, {2'h2, 32'h0})
        wr(I_MSK, 8'h3c); rd(I_MSK, v); `NBSP_CHK(v, 32'h3c)
        wr(I_MSK, 8'h00);
        $display("done: regs");
    endtask : t_regs

    task automatic t_tx;
        logic [31:0] v;
        int n, c0;
        node_blen = 8'h10;
        node_bits = 4'hb;
        wr(I_PWR, 8'h80);
        wr(I_CTL, 8'h88);
        c0 = cap_cnt;
        wr(I_BUF, 8'h5a);
        n = 0;
        while (txd_o === 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        `NBSP_CHK(n <= 18, 1'b1)
        rd(I_CTL, v); `NBSP_CHK(v[1], 1'b0)
        // Ninth bit dropped after the shift register has loaded
        wr(I_CTL, 8'h80);
        wait_cap(c0 + 1);
        `NBSP_CHK(cap, {1'b1, 1'b1, 8'h5a, 1'b0})
        rd(I_CTL, v); `NBSP_CHK(v[1], 1'b1)
        $display("done: tx");
    endtask : t_tx

    task automatic t_tx_rates;
        logic [7:0] ct[3] = '{8'h88, 8'hc0, 8'h40};
        logic [7:0] pw[3] = '{8'h00, 8'h80, 8'h80};
        logic [7:0] dd[3] = '{8'h96, 8'h3d, 8'he1};
        int c0;
        for (int i = 0; i < 3; i++) begin
            node_blen = 8'h20;
            node_bits = (i == 2) ? 4'ha : 4'hb;
            wr(I_PWR, pw[i]);
            wr(I_CTL, ct[i]);
            c0 = cap_cnt;
            wr(I_BUF, dd[i]);
            wait_cap(c0 + 1);
            if (i == 2) `NBSP_CHK(cap[9:0], {1'b1, dd[i], 1'b0})
            else `NBSP_CHK(cap, {1'b1, ct[i][3], dd[i], 1'b0})
        end
        $display("done: tx rates");
    endtask : t_tx_rates

    task automatic t_rx;
        logic [31:0] v;
        wr(I_PWR, 8'h80);
        wr(I_CTL, 8'h90);
        u_node.send(8'hc3, 1'b1, 1'b1, 1'b1, 16);
        rd(I_BUF, v); `NBSP_CHK(v, 32'hc3)
        rd(I_CTL, v); `NBSP_CHK(v[2:0], 3'b101)
        u_node.send(8'h11, 1'b0, 1'b1, 1'b1, 16);
        rd(I_BUF, v); `NBSP_CHK(v, 32'hc3)
        wr(I_CTL, 8'h90);
        u_node.send(8'h22, 1'b0, 1'b1, 1'b0, 16);
        wr(I_PWR, 8'hc0);
        rd(I_CTL, v); `NBSP_CHK(v[7], 1'b1)
        u_node.send(8'h33, 1'b1, 1'b1, 1'b1, 16);
        rd(I_CTL, v); `NBSP_CHK(v[7], 1'b1)
        wr(I_CTL, 8'h10);
        rd(I_CTL, v); `NBSP_CHK(v[7], 1'b0)
        wr(I_PWR, 8'h80);
        rd(I_CTL, v); `NBSP_CHK(v[7], 1'b1)
        $display("done: rx");
    endtask : t_rx

    task automatic t_false_start;
        logic [31:0] v;
        wr(I_CTL, 8'h90);
        u_node.glitch(4);
        repeat (40) @(posedge clk_i);
        u_node.send(8'h3c, 1'b0, 1'b1, 1'b1, 16);
        rd(I_BUF, v); `NBSP_CHK(v, 32'h3c)
        rd(I_CTL, v); `NBSP_CHK(v[2:0], 3'b001)
        $display("done: false start");
    endtask : t_false_start

    task automatic t_filter;
        logic [7:0] d[5] = '{8'ha5, 8'ha2, 8'ha0, 8'hff, 8'h55};
        logic [4:0] b9 = 5'b11011;
        logic [4:0] acc = 5'b10010;
        logic [31:0] v;
        wr(I_ADR, 8'ha4);
        wr(I_MSK, 8'hfa);
        for (int i = 0; i < 5; i++) begin
            wr(I_CTL, 8'hb0);
            u_node.send(d[i], b9[4 - i], 1'b1, 1'b1, 16);
            rd(I_CTL, v); `NBSP_CHK(v[0], acc[4 - i])
            rd(I_BUF, v);
            if (acc[4 - i]) `NBSP_CHK(v[7:0], d[i])
        end
        $display("done: filter");
    endtask : t_filter

    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        t_regs();
        t_tx();
        t_tx_rates();
        t_rx();
        t_false_start();
        t_filter();
        final_report();
    end
endmodule : nbsp_port_test

/* File: rtl/nbsp_consts.svh */
// Offsets, reset values, field positions and counts of the serial port.
// Assumes inclusion by bare name from the package and the port module.
`ifndef NBSP_CONSTS_SVH
`define NBSP_CONSTS_SVH

// ***************************************
// Register indices (byte address = 4 x index)
// ***************************************
`define NBSP_IDX_PWR 8'h87
`define NBSP_IDX_CTRL 8'h98
`define NBSP_IDX_BUF 8'h99
`define NBSP_IDX_SLAVE_MATCH_ADDRESS 8'ha9
`define NBSP_IDX_SLAVE_MATCH_MASK 8'hb9

// ***************************************
// Reset values
// ***************************************
`define NBSP_RST_BYTE 8'h00
`define NBSP_RST_TXD 1'b1

// ***************************************
// Control register bit positions
// ***************************************
`define NBSP_B_MODE_HI 7
`define NBSP_B_MODE_LO 6
`define NBSP_B_FILT 5
`define NBSP_B_REN 4
`define NBSP_B_TB8 3
`define NBSP_B_RB8 2
`define NBSP_B_TI 1
`define NBSP_B_RI 0

// ***************************************
// Power control register bit positions
// ***************************************
`define NBSP_B_DOUBLE 7
`define NBSP_B_VIEW 6

// ***************************************
// Oversampling and framing counts
// ***************************************
`define NBSP_CNT_LAST 4'hf
`define NBSP_SMP_A 4'h7
`define NBSP_SMP_B 4'h8
`define NBSP_SMP_V 4'h9
`define NBSP_TX_BITS_M1 4'h9
`define NBSP_TX_BITS_M23 4'ha
`define NBSP_RX_BITS_M1 4'h9
`define NBSP_RX_BITS_M23 4'ha

// ***************************************
// Bus answers
// ***************************************
`define NBSP_RESP_OKAY 2'h0
`define NBSP_RESP_SLVERR 2'h2

`endif

/* File: rtl/nbsp_pkg.sv */
// Types shared by the nine-bit asynchronous serial port.
// Assumes the constants header sits beside it in rtl/.
`include "nbsp_consts.svh"

package nbsp_pkg;

    // Serial control register as software sees it
    typedef struct packed {
        logic mode_select_high;
        logic mode_select_low;
        logic address_filter_enable;
        logic receive_enable;
        logic tx_ninth_bit;
        logic rx_ninth_bit;
        logic transmit_done_flag;
        logic receive_done_flag;
    } nbsp_ctrl_t;

    typedef enum logic [2:0] {
        NBSP_RX_IDLE = 3'b001,
        NBSP_RX_START = 3'b010,
        NBSP_RX_SHIFT = 3'b100
    } nbsp_rx_state_t;

endpackage : nbsp_pkg

/* File: rtl/nbsp_port.sv */
// Nine-bit asynchronous serial port: modes 1, 2 and 3 with framing error
// and automatic address recognition, registers over AXI4-Lite.
// Assumes a single 100 MHz clock; baud_ovf_i is a one-cycle pulse from
// an outside timer, used as the baud source in modes 1 and 3.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "nbsp_consts.svh"

module nbsp_port
    import nbsp_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic baud_ovf_i,
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ***************************************
    // Register state
    // ***************************************
    nbsp_ctrl_t ctrl_ff;
    logic fe_ff;
    logic double_ff;
    logic view_ff;
    logic [7:0] slave_match_address_ff;
    logic [7:0] slave_match_mask_ff;
    logic [7:0] rx_buf_ff;

    // ***************************************
    // AXI4-Lite write path
    // ***************************************
    logic aw_hold_ff;
    logic w_hold_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic [7:0] wbyte_ff;
    logic wlane_ff;
    logic wr_go;
    logic [7:0] wr_idx;
    logic wr_hit;

    assign wr_go = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    assign wr_idx = awaddr_ff[9:2];

    always_comb begin
        wr_hit = (awaddr_ff[ADDR_W-1:10] == '0) && (awaddr_ff[1:0] == 2'h0)
            && (wr_idx == `NBSP_IDX_PWR || wr_idx == `NBSP_IDX_CTRL
            || wr_idx == `NBSP_IDX_BUF || wr_idx == `NBSP_IDX_SLAVE_MATCH_ADDRESS
            || wr_idx == `NBSP_IDX_SLAVE_MATCH_MASK);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            awaddr_ff <= '0;
            wbyte_ff <= `NBSP_RST_BYTE;
            wlane_ff <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `NBSP_RESP_OKAY;
        end else begin
            // Ready is offered one cycle ahead so each channel is taken once
            s_axi_awready <= !aw_hold_ff && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_hold_ff && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wbyte_ff <= s_axi_wdata[7:0];
                wlane_ff <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `NBSP_RESP_OKAY : `NBSP_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_en;
    assign wr_en = wr_go && wr_hit && wlane_ff;

    // ***************************************
    // AXI4-Lite read path
    // ***************************************
    logic [7:0] rd_idx;
    logic [7:0] rd_byte;
    logic rd_hit;

    assign rd_idx = s_axi_araddr[9:2];

    always_comb begin
        rd_hit = (s_axi_araddr[ADDR_W-1:10] == '0)
            && (s_axi_araddr[1:0] == 2'h0);
        rd_byte = 8'h00;
        unique case (rd_idx)
            `NBSP_IDX_PWR: rd_byte = {double_ff, view_ff, 6'h00};
            `NBSP_IDX_CTRL: begin
                rd_byte = ctrl_ff;
                rd_byte[`NBSP_B_MODE_HI] = view_ff ? fe_ff
                    : ctrl_ff.mode_select_high;
            end
            `NBSP_IDX_BUF: rd_byte = rx_buf_ff;
            `NBSP_IDX_SLAVE_MATCH_ADDRESS: rd_byte = slave_match_address_ff;
            `NBSP_IDX_SLAVE_MATCH_MASK: rd_byte = slave_match_mask_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `NBSP_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_hit ? rd_byte : 8'h00};
                s_axi_rresp <= rd_hit ? `NBSP_RESP_OKAY : `NBSP_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ***************************************
    // Baud ticks at sixteen times the bit rate
    // ***************************************
    logic async_mode;
    logic timed_mode;
    logic tick_src;
    logic half_ff;
    logic tick;

    assign async_mode = ctrl_ff.mode_select_high || ctrl_ff.mode_select_low;
    // Mode 1 and 3 use the timer, mode 2 the clock itself
    assign timed_mode = ctrl_ff.mode_select_low;
    assign tick_src = timed_mode ? baud_ovf_i : 1'b1;
    // Baud double passes every source pulse, otherwise every second one
    assign tick = tick_src && (double_ff || half_ff);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            half_ff <= 1'b0;
        end else if (tick_src) begin
            half_ff <= !half_ff;
        end
    end

    // ***************************************
    // Transmitter
    // ***************************************
    logic [3:0] tx_div_ff;
    logic tx_roll;
    logic tx_pend_ff;
    logic tx_busy_ff;
    logic [9:0] tx_sh_ff;
    logic [3:0] tx_left_ff;
    logic [7:0] tx_data_ff;
    logic ti_set;
    logic buf_wr;

    assign tx_roll = tick && (tx_div_ff == `NBSP_CNT_LAST);
    assign buf_wr = wr_en && wr_idx == `NBSP_IDX_BUF && async_mode;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_div_ff <= 4'h0;
        end else if (tick) begin
            tx_div_ff <= tx_div_ff + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_pend_ff <= 1'b0;
            tx_busy_ff <= 1'b0;
            tx_sh_ff <= '1;
            tx_left_ff <= 4'h0;
            tx_data_ff <= `NBSP_RST_BYTE;
            txd_o <= `NBSP_RST_TXD;
            ti_set <= 1'b0;
        end else begin
            ti_set <= 1'b0;
            if (buf_wr) begin
                tx_data_ff <= wbyte_ff;
                tx_pend_ff <= 1'b1;
            end
            if (tx_roll) begin
                if (tx_pend_ff && !tx_busy_ff && !buf_wr) begin
                    tx_pend_ff <= 1'b0;
                    tx_busy_ff <= 1'b1;
                    txd_o <= 1'b0;
                    // Mode 1 loads a stop in the ninth slot and one spare that is never sent
                    if (ctrl_ff.mode_select_high) begin
                        tx_sh_ff <= {1'b1, ctrl_ff.tx_ninth_bit,
                            tx_data_ff};
                        tx_left_ff <= `NBSP_TX_BITS_M23;
                    end else begin
                        tx_sh_ff <= {2'b11, tx_data_ff};
                        tx_left_ff <= `NBSP_TX_BITS_M1;
                    end
                end else if (tx_busy_ff) begin
                    if (tx_left_ff == 4'h0) begin
                        tx_busy_ff <= 1'b0;
                    end else begin
                        txd_o <= tx_sh_ff[0];
                        tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
                        tx_left_ff <= tx_left_ff - 4'h1;
                        // Flag rises as the stop bit goes out
                        ti_set <= (tx_left_ff == 4'h1);
                    end
                end
            end
        end
    end

    // ***************************************
    // Receiver
    // ***************************************
    nbsp_rx_state_t rx_state_ff;
    logic rxd_prev_ff;
    logic [3:0] rx_div_ff;
    logic [3:0] rx_left_ff;
    logic smp_a_ff;
    logic smp_b_ff;
    logic vote;
    logic vote_now;
    logic [8:0] rx_sh_ff;
    logic ri_set;
    logic rb8_val;
    logic fe_set;
    logic given_ok;
    logic bcast_ok;
    logic [7:0] bcast;
    logic [7:0] rx_byte;
    logic qual_bit;
    logic accept;

    assign vote_now = tick && rx_div_ff == `NBSP_SMP_V;
    assign vote = (smp_a_ff & smp_b_ff) | (smp_a_ff & rxd_i)
        | (smp_b_ff & rxd_i);

    // Modes 2, 3: ninth in [8], byte in [7:0]; mode 1: byte in [8:1]
    assign rx_byte = ctrl_ff.mode_select_high ? rx_sh_ff[7:0]
        : rx_sh_ff[8:1];
    assign rb8_val = ctrl_ff.mode_select_high ? rx_sh_ff[8] : vote;
    assign given_ok = ((rx_byte ^ slave_match_address_ff) & slave_match_mask_ff) == 8'h00;
    assign bcast = slave_match_address_ff | slave_match_mask_ff;
    assign bcast_ok = ((rx_byte ^ bcast) & bcast) == 8'h00;
    assign qual_bit = rb8_val;
    assign accept = !ctrl_ff.receive_done_flag
        && (!ctrl_ff.address_filter_enable
        || (qual_bit && (given_ok || bcast_ok)));

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_state_ff <= NBSP_RX_IDLE;
            rxd_prev_ff <= 1'b1;
            rx_div_ff <= 4'h0;
            rx_left_ff <= 4'h0;
            smp_a_ff <= 1'b1;
            smp_b_ff <= 1'b1;
            rx_sh_ff <= '0;
            rx_buf_ff <= `NBSP_RST_BYTE;
            ri_set <= 1'b0;
            fe_set <= 1'b0;
        end else begin
            ri_set <= 1'b0;
            fe_set <= 1'b0;
            if (tick) begin
                rxd_prev_ff <= rxd_i;
                rx_div_ff <= rx_div_ff + 4'h1;
                if (rx_div_ff == `NBSP_SMP_A) begin
                    smp_a_ff <= rxd_i;
                end
                if (rx_div_ff == `NBSP_SMP_B) begin
                    smp_b_ff <= rxd_i;
                end
            end
            unique case (rx_state_ff)
                NBSP_RX_IDLE: begin
                    if (tick && async_mode && ctrl_ff.receive_enable
                        && rxd_prev_ff && !rxd_i) begin
                        rx_div_ff <= 4'h1;
                        rx_state_ff <= NBSP_RX_START;
                    end
                end
                NBSP_RX_START: begin
                    if (vote_now) begin
                        if (vote) begin
                            rx_state_ff <= NBSP_RX_IDLE;
                        end else begin
                            rx_state_ff <= NBSP_RX_SHIFT;
                            rx_left_ff <= ctrl_ff.mode_select_high
                                ? `NBSP_RX_BITS_M23 : `NBSP_RX_BITS_M1;
                        end
                    end
                end
                NBSP_RX_SHIFT: begin
                    if (vote_now) begin
                        rx_left_ff <= rx_left_ff - 4'h1;
                        if (rx_left_ff == 4'h1) begin
                            // Middle of stop bit: decide, then search again
                            rx_state_ff <= NBSP_RX_IDLE;
                            fe_set <= !vote;
                            if (accept) begin
                                rx_buf_ff <= rx_byte;
                                ri_set <= 1'b1;
                            end
                        end else begin
                            rx_sh_ff <= {vote, rx_sh_ff[8:1]};
                        end
                    end
                end
            endcase
        end
    end

    // ***************************************
    // Control, power and address registers
    // ***************************************
    logic ctrl_wr;
    assign ctrl_wr = wr_en && wr_idx == `NBSP_IDX_CTRL;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_ff <= `NBSP_RST_BYTE;
            fe_ff <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                ctrl_ff <= wbyte_ff;
                if (view_ff) begin
                    ctrl_ff.mode_select_high <= ctrl_ff.mode_select_high;
                    fe_ff <= wbyte_ff[`NBSP_B_MODE_HI];
                end
            end
            // Hardware sets win over a clearing write in the same cycle
            if (ti_set) begin
                ctrl_ff.transmit_done_flag <= 1'b1;
            end
            if (ri_set) begin
                ctrl_ff.receive_done_flag <= 1'b1;
                ctrl_ff.rx_ninth_bit <= rb8_val;
            end
            if (fe_set) begin
                fe_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            double_ff <= 1'b0;
            view_ff <= 1'b0;
            slave_match_address_ff <= `NBSP_RST_BYTE;
            slave_match_mask_ff <= `NBSP_RST_BYTE;
        end else if (wr_en) begin
            if (wr_idx == `NBSP_IDX_PWR) begin
                double_ff <= wbyte_ff[`NBSP_B_DOUBLE];
                view_ff <= wbyte_ff[`NBSP_B_VIEW];
            end
            if (wr_idx == `NBSP_IDX_SLAVE_MATCH_ADDRESS) begin
                slave_match_address_ff <= wbyte_ff;
            end
            if (wr_idx == `NBSP_IDX_SLAVE_MATCH_MASK) begin
                slave_match_mask_ff <= wbyte_ff;
            end
        end
    end

endmodule : nbsp_port
